// >>> hybrid_divert_level_ctrl.sv
// Divert latch, power-up checks and level control of the hybrid
// -------------------------------------------------------------------
// What this block does
// RULE1 - Unpowered or undiverted, relay rests so line goes to handset.
// RULE2 - Divert latch toggles on switch edge, also on remote divert edge.
// RULE3 - Divert holds until power loss, another switch operation or an enabled clear.
// RULE4 - Line-voltage break or hang-up tone clears latch when enabled.
// RULE5 - Switch lamp and remote lamp follow the divert latch.
// RULE6 - Input mute asserted while the handset holds the line.
// RULE7 - With auto-answer link, ring detector sets latch after preset rings.
// RULE8 - Power-up self test; status LED flashes on any failure.
// RULE9 - After power-up, links read and mode and levels set from them.
// RULE10 - Divert and two/four wire mode driven out, line side event inputs debounced.
// RULE11 - Transmit LED on above -14dB, off only below -17dB.
// RULE12 - Transmit gain reduced below -24dB, then level set before codec.
// RULE13 - Receive LED on above -14dB; receive gain reduced below -24dB.
// RULE14 - Receive output disabled off line, after overload limiting.
// RULE15 - Levelling with dominant send reduces receive gain further.
// RULE16 - Levelling modes off, low up to 12dB, high up to 24dB.
// RULE17 - Levelling moves 1dB per 5ms, 8dB band with no processing.
// RULE18 - Adaption stops during double-talk and at low signal level.
// RULE19 - Coefficients held unchanged while no signal is present.
// RULE20 - Cancellation window spans 28ms of echo.
// RULE21 - Links may select half duplex instead of full duplex.
// RULE22 - Send path order: overload limit, high-pass, then cancellation.
// RULE23 - Debounced input accepted after holding level for fixed samples.
// -------------------------------------------------------------------
`default_nettype none
module hybrid_divert_level_ctrl (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Line side events, asynchronous
   input  wire logic        divert_switch,
   input  wire logic        remote_divert,
   input  wire logic        line_break,
   input  wire logic        hangup_tone,
   input  wire logic        ring_burst,
   input  wire logic        handset_off_hook,
   // Configuration links, asynchronous
   input  wire logic        clear_enable,
   input  wire logic        auto_answer_link,
   input  wire logic [2:0]  ring_count_preset,
   input  wire logic [1:0]  level_mode_link,
   input  wire logic        half_duplex_link,
   input  wire logic        four_wire_link,
   input  wire logic        cancel_enable_link,
   input  wire logic [1:0]  tx_level_link,
   input  wire logic [1:0]  rx_level_link,
   // Self test results, same clock
   input  wire logic        test_done,
   input  wire logic        test_fail,
   // Signal levels and flags from the sample path, same clock
   input  wire logic signed [7:0] tx_level_db,
   input  wire logic signed [7:0] rx_level_db,
   input  wire logic        tx_overload,
   input  wire logic        rx_overload,
   input  wire logic        double_talk,
   // Transmit sample stream in
   input  wire logic [15:0] tx_in_data,
   input  wire logic        tx_in_valid,
   output logic             tx_in_ready,
   // Transmit sample stream to codec send port
   output logic [15:0]      tx_out_data,
   output logic             tx_out_valid,
   input  wire logic        tx_out_ready,
   // Relay, lamps and mode outputs
   output logic             divert_relay,
   output logic             switch_lamp,
   output logic             remote_lamp,
   output logic             input_mute,
   output logic             four_wire_mode,
   output logic             half_duplex,
   output logic             status_led,
   output logic             tx_led,
   output logic             rx_led,
   output logic             rx_output_enable,
   // Gain and cancellation controls
   output logic [5:0]       tx_gain_cut,
   output logic [5:0]       rx_gain_cut,
   output logic [1:0]       tx_level_set,
   output logic [1:0]       rx_level_set,
   output logic             tx_limit,
   output logic             rx_limit,
   output logic             highpass_enable,
   output logic             cancel_enable,
   output logic             adapt_enable,
   output logic             coeff_hold,
   output logic [7:0]       echo_taps
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 20;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   wire  [NSYNC-1:0] async_in = {divert_switch, remote_divert, line_break,
                      hangup_tone, ring_burst, handset_off_hook,
                      clear_enable, auto_answer_link, ring_count_preset,
                      level_mode_link, half_duplex_link, four_wire_link,
                      cancel_enable_link, tx_level_link, rx_level_link};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= async_in;
         sync2 <= sync1;
      end
   end

   // ----------------------------------------------------------------
   // Debounce of control inputs
   // ----------------------------------------------------------------
   localparam int NDB = 6;
   logic [NDB-1:0] db;
   logic [NDB-1:0] db_prev;
   logic [11:0]    db_cnt [NDB];
   wire  [NDB-1:0] db_raw = sync2[NSYNC-1 -: NDB];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         db      <= '0;
         db_prev <= '0;
         for (int i = 0; i < NDB; i++) begin
            db_cnt[i] <= '0;
         end
      end else begin
         db_prev <= db;
         for (int i = 0; i < NDB; i++) begin
            if (db_raw[i] == db[i]) begin
               db_cnt[i] <= '0;
            end else if (db_cnt[i] ==
                         12'(hybrid_ctrl_pkg::DEBOUNCE_CYC - 1)) begin
               db[i]     <= db_raw[i];                         // [RULE23]
               db_cnt[i] <= '0;
            end else begin
               db_cnt[i] <= db_cnt[i] + 12'h001;
            end
         end
      end
   end                                                         // [RULE10]

   wire sw_edge   = db[5] & ~db_prev[5];
   wire rem_edge  = db[4] & ~db_prev[4];
   wire brk_rise  = db[3] & ~db_prev[3];
   wire tone_rise = db[2] & ~db_prev[2];
   wire ring_rise = db[1] & ~db_prev[1];
   wire off_hook  = db[0];

   // ----------------------------------------------------------------
   // Power-up sequencing and link capture
   // ----------------------------------------------------------------
   hybrid_ctrl_pkg::boot_state_t state;
   logic        lk_clear;
   logic        lk_auto;
   logic [2:0]  lk_rings;
   logic [1:0]  lk_level;
   logic        lk_half;
   logic        lk_four;
   logic        lk_cancel;
   wire         running = (state == hybrid_ctrl_pkg::ST_RUN);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= hybrid_ctrl_pkg::ST_TEST;
      end else begin
         unique case (state)
            hybrid_ctrl_pkg::ST_TEST: begin
               if (test_done) begin
                  state <= test_fail ? hybrid_ctrl_pkg::ST_FAIL
                                     : hybrid_ctrl_pkg::ST_LINK; // [RULE8]
               end
            end
            hybrid_ctrl_pkg::ST_LINK: state <= hybrid_ctrl_pkg::ST_RUN;
            hybrid_ctrl_pkg::ST_RUN:  state <= hybrid_ctrl_pkg::ST_RUN;
            hybrid_ctrl_pkg::ST_FAIL: state <= hybrid_ctrl_pkg::ST_FAIL;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lk_clear     <= 1'b0;
         lk_auto      <= 1'b0;
         lk_rings     <= hybrid_ctrl_pkg::RING_MIN;
         lk_level     <= hybrid_ctrl_pkg::LVL_OFF;
         lk_half      <= 1'b0;
         lk_four      <= 1'b0;
         lk_cancel    <= 1'b0;
         tx_level_set <= 2'h0;
         rx_level_set <= 2'h0;
      end else if (state == hybrid_ctrl_pkg::ST_LINK) begin
         lk_clear     <= sync2[13];                            // [RULE9]
         lk_auto      <= sync2[12];
         if (sync2[11:9] < hybrid_ctrl_pkg::RING_MIN) begin
            lk_rings <= hybrid_ctrl_pkg::RING_MIN;
         end else if (sync2[11:9] > hybrid_ctrl_pkg::RING_MAX) begin
            lk_rings <= hybrid_ctrl_pkg::RING_MAX;
         end else begin
            lk_rings <= sync2[11:9];
         end
         lk_level     <= sync2[8:7];
         lk_half      <= sync2[6];                             // [RULE21]
         lk_four      <= sync2[5];
         lk_cancel    <= sync2[4];
         tx_level_set <= sync2[3:2];                           // [RULE12]
         rx_level_set <= sync2[1:0];
      end
   end
   // Status LED flashes after a failed self test
   logic [25:0] flash_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flash_cnt  <= '0;
         status_led <= 1'b0;
      end else if (state == hybrid_ctrl_pkg::ST_FAIL) begin
         if (flash_cnt == 26'(hybrid_ctrl_pkg::FLASH_CYC - 1)) begin
            flash_cnt  <= '0;
            status_led <= ~status_led;                         // [RULE8]
         end else begin
            flash_cnt <= flash_cnt + 26'h0000001;
         end
      end else begin
         status_led <= running;
      end
   end

   // ----------------------------------------------------------------
   // Divert latch and ring counter
   // ----------------------------------------------------------------
   logic       diverted;
   logic [2:0] rings;
   wire        ring_set  = lk_auto && ring_rise && !diverted &&
                           (rings + 3'h1 >= lk_rings);         // [RULE7]
   wire        clear_req = lk_clear && (brk_rise || tone_rise); // [RULE4]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         diverted <= 1'b0;                                     // [RULE1]
      end else if (running) begin
         if (sw_edge || rem_edge) begin
            diverted <= ~diverted;                          // [RULE2] [RULE3]
         end else if (clear_req) begin
            diverted <= 1'b0;
         end else if (ring_set) begin
            diverted <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rings <= '0;
      end else if (diverted || !lk_auto) begin
         rings <= '0;
      end else if (ring_rise) begin
         rings <= rings + 3'h1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divert_relay   <= 1'b0;
         switch_lamp    <= 1'b0;
         remote_lamp    <= 1'b0;
         input_mute     <= 1'b1;
         four_wire_mode <= 1'b0;
         half_duplex    <= 1'b0;
      end else begin
         divert_relay   <= diverted;                           // [RULE10]
         switch_lamp    <= diverted;                           // [RULE5]
         remote_lamp    <= diverted;
         input_mute     <= !diverted || off_hook;              // [RULE6]
         four_wire_mode <= lk_four;
         half_duplex    <= lk_half;
      end
   end

   // ----------------------------------------------------------------
   // Meters, gain reduction and limiting
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_led <= 1'b0;
         rx_led <= 1'b0;
      end else begin
         if (tx_level_db > hybrid_ctrl_pkg::LED_ON_DB) begin
            tx_led <= 1'b1;                                    // [RULE11]
         end else if (tx_level_db < hybrid_ctrl_pkg::LED_OFF_DB) begin
            tx_led <= 1'b0;
         end
         if (rx_level_db > hybrid_ctrl_pkg::LED_ON_DB) begin
            rx_led <= 1'b1;                                    // [RULE13]
         end else if (rx_level_db < hybrid_ctrl_pkg::LED_OFF_DB) begin
            rx_led <= 1'b0;
         end
      end
   end

   wire tx_low = tx_level_db < hybrid_ctrl_pkg::LOW_LEVEL_DB;
   wire rx_low = rx_level_db < hybrid_ctrl_pkg::LOW_LEVEL_DB;
   // Duplex levelling, stepping 1dB each 5ms
   logic [5:0]        lvl_gain;
   logic [19:0]       step_cnt;
   wire  [5:0]        lvl_max  = (lk_level == hybrid_ctrl_pkg::LVL_HIGH)
                     ? hybrid_ctrl_pkg::LEVEL_HIGH_MAX
                     : (lk_level == hybrid_ctrl_pkg::LVL_LOW)
                       ? hybrid_ctrl_pkg::LEVEL_LOW_MAX : 6'h00; // [RULE16]
   wire signed [8:0]  lvl_diff = 9'(tx_level_db) - 9'(rx_level_db);
   wire               send_dom =
                      lvl_diff > 9'(hybrid_ctrl_pkg::HYST_DB);   // [RULE17]
   wire               rx_dom   = lvl_diff < -9'(hybrid_ctrl_pkg::HYST_DB);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_cnt <= '0;
         lvl_gain <= '0;
      end else if (step_cnt == 20'(hybrid_ctrl_pkg::STEP_CYC - 1)) begin
         step_cnt <= '0;
         if (lvl_gain > lvl_max) begin
            lvl_gain <= lvl_max;
         end else if (send_dom && lvl_gain < lvl_max) begin
            lvl_gain <= lvl_gain + 6'h01;                      // [RULE17]
         end else if (rx_dom && lvl_gain != 6'h00) begin
            lvl_gain <= lvl_gain - 6'h01;
         end
      end else begin
         step_cnt <= step_cnt + 20'h00001;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_gain_cut      <= '0;
         rx_gain_cut      <= '0;
         tx_limit         <= 1'b0;
         rx_limit         <= 1'b0;
         rx_output_enable <= 1'b0;
      end else begin
         tx_limit         <= tx_overload;                      // [RULE22]
         rx_limit         <= rx_overload;                      // [RULE14]
         rx_output_enable <= running && diverted;              // [RULE14]
         tx_gain_cut <= tx_low ? hybrid_ctrl_pkg::NOISE_RED_DB
                               : 6'h00;                        // [RULE12]
         rx_gain_cut <= (rx_low ? hybrid_ctrl_pkg::NOISE_RED_DB
                                : 6'h00)                       // [RULE13]
                        + (send_dom ? lvl_gain : 6'h00);       // [RULE15]
      end
   end

   // ----------------------------------------------------------------
   // Cancellation control
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         highpass_enable <= 1'b0;
         cancel_enable   <= 1'b0;
         adapt_enable    <= 1'b0;
         coeff_hold      <= 1'b1;
         echo_taps       <= '0;
      end else begin
         highpass_enable <= running;                           // [RULE22]
         cancel_enable   <= running && lk_cancel;
         adapt_enable    <= running && lk_cancel && !double_talk
                            && !tx_low && !rx_low;             // [RULE18]
         coeff_hold      <= tx_low && rx_low;                  // [RULE19]
         echo_taps       <= 8'(hybrid_ctrl_pkg::ECHO_TAPS);    // [RULE20]
      end
   end

   // ----------------------------------------------------------------
   // Two-entry transmit buffer towards codec send port
   // ----------------------------------------------------------------
   logic [15:0] buf_mem [2];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  count;
   wire         push = tx_in_valid && tx_in_ready;
   wire         pop  = tx_out_valid && tx_out_ready;
   assign tx_in_ready  = (count != 2'h2);
   assign tx_out_valid = (count != 2'h0);
   assign tx_out_data  = buf_mem[rd_ptr];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         buf_mem[0] <= '0;
         buf_mem[1] <= '0;
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         count      <= '0;
      end else begin
         if (push) begin
            buf_mem[wr_ptr] <= tx_in_data;
            wr_ptr          <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule
`default_nettype wire

// >>> hybrid_ctrl_pkg.sv
// Constants for the telephone hybrid control block
`default_nettype none
package hybrid_ctrl_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ          = 200_000_000;
   localparam int DEBOUNCE_US     = 10;
   localparam int DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int STEP_MS         = 5;
   localparam int STEP_CYC        = STEP_MS * (CLK_HZ / 1_000);
   localparam int FLASH_MS        = 250;
   localparam int FLASH_CYC       = FLASH_MS * (CLK_HZ / 1_000);
   localparam int ECHO_MS         = 28;
   localparam int SAMPLE_HZ       = 8_000;
   localparam int ECHO_TAPS       = ECHO_MS * SAMPLE_HZ / 1_000;
   // -----------------------------------------------------------------
   // Levels as signed dB codes below full scale, gain amounts as unsigned dB
   // -----------------------------------------------------------------
   localparam logic signed [7:0] LED_ON_DB       = -8'sd14;
   localparam logic signed [7:0] LED_OFF_DB      = -8'sd17;
   localparam logic signed [7:0] LOW_LEVEL_DB    = -8'sd24;
   localparam logic [5:0]        LEVEL_LOW_MAX   = 6'd12;
   localparam logic [5:0]        LEVEL_HIGH_MAX  = 6'd24;
   localparam logic signed [7:0] HYST_DB         = 8'sd8;
   localparam logic [5:0]        NOISE_RED_DB    = 6'd12;
   // -----------------------------------------------------------------
   // Ring counts, levelling modes and boot states
   // -----------------------------------------------------------------
   localparam logic [2:0] RING_MIN = 3'd1;
   localparam logic [2:0] RING_MAX = 3'd5;
   typedef enum logic [1:0] {
      LVL_OFF  = 2'b00,
      LVL_LOW  = 2'b01,
      LVL_HIGH = 2'b10
   } level_mode_t;
   typedef enum logic [1:0] {
      ST_TEST = 2'b00,
      ST_LINK = 2'b01,
      ST_RUN  = 2'b10,
      ST_FAIL = 2'b11
   } boot_state_t;
endpackage
`default_nettype wire

// >>> hybrid_ctrl_sva.sv
// Assertion checker for the hybrid divert and level control block
`default_nettype none
module hybrid_ctrl_sva (
   // Clock, reset, line events, double talk and transmit level
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              divert_switch,
   input wire logic              remote_divert,
   input wire logic              line_break,
   input wire logic              hangup_tone,
   input wire logic              ring_burst,
   input wire logic              double_talk,
   input wire logic signed [7:0] tx_level_db,
   // Sample stream
   input wire logic              tx_in_valid,
   input wire logic              tx_in_ready,
   input wire logic [15:0]       tx_out_data,
   input wire logic              tx_out_valid,
   input wire logic              tx_out_ready,
   // Outputs under watch
   input wire logic              divert_relay,
   input wire logic              switch_lamp,
   input wire logic              remote_lamp,
   input wire logic              input_mute,
   input wire logic              rx_output_enable,
   input wire logic              tx_led,
   input wire logic              adapt_enable,
   input wire logic [7:0]        echo_taps
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // -----------------------------------------------------------------
   // Cycles since last line event
   // -----------------------------------------------------------------
   logic [4:0] quiet;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         quiet <= 5'h00;
      else if (divert_switch | remote_divert | line_break | hangup_tone |
               ring_burst)
         quiet <= 5'h00;
      else if (quiet != 5'h1f)
         quiet <= quiet + 5'h01;
   end
   sequence stalled_word;
      tx_out_valid && !tx_out_ready;
   endsequence
   sequence word_taken;
      tx_in_valid && tx_in_ready;
   endsequence
   // -----------------------------------------------------------------
   // Properties
   // -----------------------------------------------------------------
   relay_hold_a: assert property (quiet > 5'h08 |=> $stable(divert_relay))
      else $error("Relay moved unprompted");
   lamp_follow_a: assert property (switch_lamp == divert_relay &&
      remote_lamp == divert_relay) else $error("Lamps differ from relay");
   mute_idle_a: assert property (!divert_relay [*2] |-> input_mute)
      else $error("Input not muted");
   rx_off_a: assert property (!divert_relay [*2] |-> !rx_output_enable)
      else $error("Rx output on off line");
   led_on_a: assert property (rx_output_enable &&
      tx_level_db > hybrid_ctrl_pkg::LED_ON_DB |=> tx_led)
      else $error("Tx LED not lit");
   led_off_a: assert property (tx_level_db < hybrid_ctrl_pkg::LED_OFF_DB
      |=> !tx_led) else $error("Tx LED still lit");
   led_band_a: assert property (tx_level_db >= hybrid_ctrl_pkg::LED_OFF_DB
      && tx_level_db <= hybrid_ctrl_pkg::LED_ON_DB |=> $stable(tx_led))
      else $error("Tx LED moved in band");
   adapt_stop_a: assert property (double_talk |=> !adapt_enable)
      else $error("Adapting in double talk");
   word_hold_a: assert property (stalled_word |=>
      tx_out_valid && $stable(tx_out_data)) else $error("Stalled word lost");
   word_out_a: assert property (word_taken |=> tx_out_valid)
      else $error("Accepted word not offered next cycle");
   echo_span_a: assert property (!$past(rst) |-> echo_taps == 8'he0)
      else $error("Echo window not 224 taps");
endmodule
`default_nettype wire

// >>> telephone_far_end.sv
// Model of the telephone line, handset and remote divert switch
`default_nettype none
module telephone_far_end (
   // Clock and contacts
   input  wire logic clk,
   output logic      divert_switch,
   output logic      remote_divert,
   output logic      line_break,
   output logic      hangup_tone,
   output logic      ring_burst,
   output logic      handset_off_hook
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] pins = 6'h00;
   assign {handset_off_hook, ring_burst, hangup_tone, line_break,
           remote_divert, divert_switch} = pins;
   // Holds a contact past debounce, then releases it as long
   task automatic press(input int k);
      @(negedge clk) pins[k] = 1'b1;
      repeat (2100) @(negedge clk);
      pins[k] = 1'b0;
      repeat (2100) @(negedge clk);
   endtask
   task automatic hold(input int k, input logic v);
      @(negedge clk) pins[k] = v;
   endtask
endmodule
`default_nettype wire

// >>> hybrid_divert_level_ctrl_tb_top.sv
// Testbench top for the hybrid divert and level control block
`default_nettype none
module hybrid_divert_level_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic clk = 1'b0, rst = 1'b1, test_done = 1'b0, test_fail = 1'b0;
   logic clear_enable = 1'b1, auto_answer_link = 1'b1, tx_overload = 1'b0;
   logic half_duplex_link = 1'b1, four_wire_link = 1'b1, rx_overload = 1'b0;
   logic cancel_enable_link = 1'b1, double_talk = 1'b0, tx_in_valid = 1'b0;
   logic tx_out_ready = 1'b1;
   logic [2:0] ring_count_preset = 3'h2;
   logic [1:0] level_mode_link = 2'h1, tx_level_link = 2'h2;
   logic [1:0] rx_level_link = 2'h1, tx_level_set, rx_level_set;
   logic signed [7:0] tx_level_db = 8'hd8, rx_level_db = 8'hd8;
   logic [15:0] tx_in_data = 16'h0000, tx_out_data;
   logic [5:0] tx_gain_cut, rx_gain_cut;
   logic [7:0] echo_taps;
   logic divert_switch, remote_divert, line_break, hangup_tone, ring_burst;
   logic handset_off_hook, tx_in_ready, tx_out_valid, divert_relay;
   logic switch_lamp, remote_lamp, input_mute, four_wire_mode, half_duplex;
   logic status_led, tx_led, rx_led, rx_output_enable, tx_limit, rx_limit;
   logic highpass_enable, cancel_enable, adapt_enable, coeff_hold;
   int n_mismatch = 0;
   int check_count = 0;
   hybrid_divert_level_ctrl dut (.*);
   telephone_far_end far (.*);
   initial forever #2.5 clk = ~clk;
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_boot();
      int i;
      check("divert_relay", divert_relay, 16'h0000);
      check("input_mute", input_mute, 16'h0001);
      rst = 1'b0;
      settle(2);
      test_done = 1'b1;
      for (i = 0; i < 20 && status_led !== 1'b1; i++)
         settle(1);
      if (i == 20) begin
         n_mismatch++;
         results();
      end
      settle(2);
      check("status_led", status_led, 16'h0001);
      check("four_wire_mode", four_wire_mode, 16'h0001);
      check("half_duplex", half_duplex, 16'h0001);
      check("tx_level_set", tx_level_set, 16'h0002);
      check("rx_level_set", rx_level_set, 16'h0001);
      check("cancel_enable", cancel_enable, 16'h0001);
      check("echo_taps", echo_taps, 16'h00e0);
      $display("test boot done");
   endtask
   task automatic t_divert();
      far.press(0);
      check("divert_relay", divert_relay, 16'h0001);
      check("switch_lamp", switch_lamp, 16'h0001);
      check("remote_lamp", remote_lamp, 16'h0001);
      check("input_mute", input_mute, 16'h0000);
      check("rx_output_enable", rx_output_enable, 16'h0001);
      far.hold(5, 1'b1);
      settle(2100);
      check("input_mute", input_mute, 16'h0001);
      far.hold(5, 1'b0);
      settle(2100);
      far.press(1);
      check("divert_relay", divert_relay, 16'h0000);
      check("rx_output_enable", rx_output_enable, 16'h0000);
      for (int k = 2; k < 4; k++) begin
         far.press(0);
         check("divert_relay", divert_relay, 16'h0001);
         far.press(k);
         check("divert_relay", divert_relay, 16'h0000);
      end
      far.press(4);
      check("divert_relay", divert_relay, 16'h0000);
      far.press(4);
      check("divert_relay", divert_relay, 16'h0001);
      $display("test divert done");
   endtask
   task automatic t_levels();
      tx_level_db = 8'hf6;
      rx_level_db = 8'hf6;
      settle(2);
      check("tx_led", tx_led, 16'h0001);
      check("rx_led", rx_led, 16'h0001);
      tx_level_db = 8'hf1;
      settle(2);
      check("tx_led", tx_led, 16'h0001);
      tx_level_db = 8'hee;
      settle(2);
      check("tx_led", tx_led, 16'h0000);
      tx_level_db = 8'hf1;
      settle(2);
      check("tx_led", tx_led, 16'h0000);
      tx_level_db = 8'he2;
      rx_level_db = 8'he2;
      double_talk = 1'b1;
      tx_overload = 1'b1;
      rx_overload = 1'b1;
      settle(3);
      check("tx_gain_cut", tx_gain_cut, 16'(hybrid_ctrl_pkg::NOISE_RED_DB));
      check("rx_gain_cut", rx_gain_cut, 16'(hybrid_ctrl_pkg::NOISE_RED_DB));
      check("coeff_hold", coeff_hold, 16'h0001);
      check("adapt_enable", adapt_enable, 16'h0000);
      check("tx_limit", tx_limit, 16'h0001);
      check("rx_limit", rx_limit, 16'h0001);
      double_talk = 1'b0;
      tx_overload = 1'b0;
      rx_overload = 1'b0;
      $display("test levels done");
   endtask
   task automatic t_buffer();
      logic [15:0] w [2] = '{16'h1111, 16'h2222};
      tx_out_ready = 1'b0;
      foreach (w[i]) begin
         tx_in_data = w[i];
         tx_in_valid = 1'b1;
         settle(1);
      end
      tx_in_valid = 1'b0;
      check("tx_in_ready", tx_in_ready, 16'h0000);
      check("tx_out_data", tx_out_data, 16'h1111);
      tx_out_ready = 1'b1;
      settle(1);
      check("tx_out_data", tx_out_data, 16'h2222);
      settle(1);
      check("tx_out_valid", tx_out_valid, 16'h0000);
      $display("test buffer done");
   endtask
   initial begin
      settle(10);
      t_boot();
      t_divert();
      t_levels();
      t_buffer();
      results();
   end
endmodule
bind hybrid_divert_level_ctrl hybrid_ctrl_sva chk (.*);
`default_nettype wire
